/* File: drive_word_pkg.sv */
// constants and carriers for the drive control/status word block
// assumes one 50 MHz clock domain and a plain strobe register port
package drive_word_pkg;

    localparam int AW = 8;
    localparam int DW = 32;
    localparam int WW = 16;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CFG    = 8'h08;
    localparam logic [7:0] OFS_JOG1   = 8'h0C;
    localparam logic [7:0] OFS_JOG2   = 8'h10;
    localparam logic [7:0] OFS_STEP   = 8'h14;
    localparam logic [7:0] OFS_REF    = 8'h18;
    localparam logic [7:0] OFS_CURTIM = 8'h1C;
    localparam logic [7:0] OFS_STATE  = 8'h20;

    // config register fields
    localparam int CFG_NATIVE = 0;
    localparam int CFG_RELAY  = 1;
    localparam int CFG_RAMP2  = 2;
    localparam logic [2:0] CFG_RST = 3'h0;

    // control word bit positions
    localparam int CW_ON1   = 0;
    localparam int CW_ON2   = 1;
    localparam int CW_ON3   = 2;
    localparam int CW_COAST = 3;
    localparam int CW_RESET = 7;
    localparam int CW_JOG1  = 8;
    localparam int CW_JOG2  = 9;
    localparam int CW_VALID = 10;
    localparam int CW_SLOW  = 11;
    localparam int CW_CATCH = 12;

    // status word bit positions
    localparam int ST_CTRL_RDY  = 0;
    localparam int ST_DRV_RDY   = 1;
    localparam int ST_COAST     = 2;
    localparam int ST_TRIP      = 3;
    localparam int ST_OFF2      = 4;
    localparam int ST_OFF3      = 5;
    localparam int ST_LOCK_INH  = 6;
    localparam int ST_WARN      = 7;
    localparam int ST_AT_REF    = 8;
    localparam int ST_SERIAL    = 9;
    localparam int ST_IN_LIMIT  = 10;
    localparam int ST_RUNNING   = 11;
    localparam int ST_VOLT      = 13;
    localparam int ST_CURLIM    = 14;
    localparam int ST_THERMAL   = 15;

    localparam logic [WW-1:0] WORD_ZERO = 16'h0000;
    localparam logic [WW-1:0] WORD_MAX  = 16'hFFFF;
    localparam logic [WW-1:0] CUR_ONE   = 16'h0001;
    localparam logic [WW-1:0] CURTIM_RST = 16'h0064;
    localparam logic [DW-1:0] RD_ZERO   = 32'h0000_0000;

    // drive conditions from the surrounding drive logic
    typedef struct packed {
        logic drive_ready;
        logic start_cond;
        logic start_sig;
        logic freq_nonzero;
        logic warning;
        logic at_ref;
        logic panel_stop;
        logic local_sel;
        logic at_freq_limit;
        logic dc_out_window;
        logic over_current;
        logic over_temp;
        logic trip_evt;
        logic lock_evt;
    } drive_cond_s;

    typedef struct packed {
        logic [WW-1:0] cw;
        logic [2:0]    cfg;
        logic [WW-1:0] jog1;
        logic [WW-1:0] jog2;
        logic [WW-1:0] step;
        logic [WW-1:0] ref_val;
        logic [WW-1:0] cur_time;
        logic [WW-1:0] cur_cnt;
        logic          rst_prev;
        logic          trip;
        logic          lock;
        logic          inhibit;
        logic          stop_pend;
        logic [DW-1:0] rdata;
        logic [WW-1:0] status;
        logic [WW-1:0] freq_cmd;
        logic          ramp_stop;
        logic          ramp2;
        logic          relay;
        logic          start_ok;
    } word_state_s;

endpackage

/* File: drive_word_ctrl.sv */
// control word decoder and status word builder for a motor drive
// assumes single clock, synchronous inputs, master on a strobe port
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module drive_word_ctrl (
    // clock and reset
    input  wire logic                              MCLK_I,
    input  wire logic                              RST_I,
    // register port
    input  wire logic [drive_word_pkg::AW-1:0]     ADDR_I,
    input  wire logic [drive_word_pkg::DW-1:0]     WDATA_I,
    input  wire logic                              WR_I,
    input  wire logic                              RD_I,
    output logic      [drive_word_pkg::DW-1:0]     RDATA_O,
    // drive conditions
    input  wire drive_word_pkg::drive_cond_s       COND_I,
    // drive commands and status
    output logic      [drive_word_pkg::WW-1:0]     STATUS_O,
    output logic      [drive_word_pkg::WW-1:0]     FREQ_CMD_O,
    output logic                                   RAMP_STOP_O,
    output logic                                   RAMP2_SEL_O,
    output logic                                   RELAY_O,
    output logic                                   START_OK_O,
    output logic                                   TRIP_O
);

    drive_word_pkg::word_state_s r;
    drive_word_pkg::word_state_s n;

    function automatic logic hit(input logic [drive_word_pkg::AW-1:0] a,
                                 input logic [7:0] o);
        hit = (a == o);
    endfunction

    function automatic logic [drive_word_pkg::DW-1:0] z16(
        input logic [drive_word_pkg::WW-1:0] v);
        z16 = {16'h0000, v};
    endfunction

    logic                            fieldbus;
    logic                            serial_ok;
    logic                            on_all;
    logic                            cw_take;
    logic [drive_word_pkg::WW-1:0]   cw_new;
    logic                            rst_edge;
    logic                            cur_expire;
    logic [16:0]                     sum;
    logic [drive_word_pkg::WW-1:0]   st;

    always_comb begin
        n = r;
        fieldbus = ~r.cfg[drive_word_pkg::CFG_NATIVE];
        serial_ok = ~(COND_I.panel_stop | COND_I.local_sel);
        cw_take = WR_I & hit(ADDR_I, drive_word_pkg::OFS_CTRL) & serial_ok
                  & WDATA_I[drive_word_pkg::CW_VALID];
        cw_new = cw_take ? WDATA_I[15:0] : r.cw;
        n.cw = cw_new;
        on_all = &cw_new[drive_word_pkg::CW_ON3:drive_word_pkg::CW_ON1];

        // config and setting registers
        if (WR_I & hit(ADDR_I, drive_word_pkg::OFS_CFG)) begin
            n.cfg = WDATA_I[2:0];
        end else if (WR_I & hit(ADDR_I, drive_word_pkg::OFS_JOG1)) begin
            n.jog1 = WDATA_I[15:0];
        end else if (WR_I & hit(ADDR_I, drive_word_pkg::OFS_JOG2)) begin
            n.jog2 = WDATA_I[15:0];
        end else if (WR_I & hit(ADDR_I, drive_word_pkg::OFS_STEP)) begin
            n.step = WDATA_I[15:0];
        end else if (WR_I & hit(ADDR_I, drive_word_pkg::OFS_REF)) begin
            n.ref_val = WDATA_I[15:0];
        end else if (WR_I & hit(ADDR_I, drive_word_pkg::OFS_CURTIM)) begin
            n.cur_time = WDATA_I[15:0];
        end

        // over-current persistence; counter holds at limit
        cur_expire = 1'b0;
        if (COND_I.over_current) begin
            if (r.cur_cnt >= r.cur_time) begin
                cur_expire = 1'b1;
            end else begin
                n.cur_cnt = r.cur_cnt + drive_word_pkg::CUR_ONE;
            end
        end else begin
            n.cur_cnt = drive_word_pkg::WORD_ZERO;
        end

        // trip handling; a new fault beats a reset in the same cycle
        n.rst_prev = cw_new[drive_word_pkg::CW_RESET];
        rst_edge = cw_new[drive_word_pkg::CW_RESET] & ~r.rst_prev;
        if (COND_I.lock_evt) begin
            n.lock = 1'b1;
        end
        if (COND_I.trip_evt | COND_I.lock_evt | cur_expire) begin
            n.trip = 1'b1;
        end else if (rst_edge & r.trip & ~r.lock) begin
            n.trip = 1'b0;
        end

        // start inhibit; setting terms win over the clear pattern
        if ((rst_edge & r.trip & ~r.lock & ~COND_I.trip_evt & ~COND_I.lock_evt & ~cur_expire)
            | (fieldbus & cw_take & ~(cw_new[drive_word_pkg::CW_ON2]
                                      & cw_new[drive_word_pkg::CW_ON3]))) begin
            n.inhibit = 1'b1;
        end else if (~cw_new[drive_word_pkg::CW_ON1] & cw_new[drive_word_pkg::CW_ON2]
                     & cw_new[drive_word_pkg::CW_ON3]
                     & cw_new[drive_word_pkg::CW_VALID]) begin
            n.inhibit = 1'b0;
        end

        // ramped stop and relay
        n.ramp_stop = fieldbus & ~on_all;
        n.ramp2 = r.cfg[drive_word_pkg::CFG_RAMP2];
        if (fieldbus & ~on_all) begin
            n.stop_pend = 1'b1;
        end else begin
            n.stop_pend = 1'b0;
        end
        n.relay = r.cfg[drive_word_pkg::CFG_RELAY] & r.stop_pend
                  & ~COND_I.freq_nonzero;
        n.start_ok = COND_I.start_cond & ~r.trip
                     & (~fieldbus | (on_all & ~r.inhibit));

        // frequency command; jog beats offset, slow-down beats catch-up
        sum = {1'b0, r.ref_val} + {1'b0, r.step};
        if (~fieldbus) begin
            n.freq_cmd = r.ref_val;
        end else if (cw_new[drive_word_pkg::CW_JOG1]) begin
            n.freq_cmd = r.jog1;
        end else if (cw_new[drive_word_pkg::CW_JOG2]) begin
            n.freq_cmd = r.jog2;
        end else if (cw_new[drive_word_pkg::CW_SLOW]) begin
            n.freq_cmd = (r.ref_val > r.step) ? r.ref_val - r.step
                         : drive_word_pkg::WORD_ZERO;
        end else if (cw_new[drive_word_pkg::CW_CATCH]) begin
            n.freq_cmd = sum[16] ? drive_word_pkg::WORD_MAX : sum[15:0];
        end else begin
            n.freq_cmd = r.ref_val;
        end

        // status word assembly; unlisted bits stay zero
        st = drive_word_pkg::WORD_ZERO;
        st[drive_word_pkg::ST_DRV_RDY] = COND_I.drive_ready;
        st[drive_word_pkg::ST_TRIP] = r.trip;
        st[drive_word_pkg::ST_WARN] = COND_I.warning;
        st[drive_word_pkg::ST_AT_REF] = COND_I.at_ref;
        st[drive_word_pkg::ST_SERIAL] = serial_ok;
        st[drive_word_pkg::ST_IN_LIMIT] = ~COND_I.at_freq_limit;
        st[drive_word_pkg::ST_RUNNING] = COND_I.start_sig | COND_I.freq_nonzero;
        st[drive_word_pkg::ST_VOLT] = COND_I.dc_out_window;
        st[drive_word_pkg::ST_CURLIM] = COND_I.over_current;
        st[drive_word_pkg::ST_THERMAL] = COND_I.over_temp;
        if (fieldbus) begin
            st[drive_word_pkg::ST_CTRL_RDY] = on_all & COND_I.drive_ready;
            st[drive_word_pkg::ST_COAST] = on_all & cw_new[drive_word_pkg::CW_COAST]
                                           & ~r.trip;
            st[drive_word_pkg::ST_OFF2] = ~cw_new[drive_word_pkg::CW_ON2];
            st[drive_word_pkg::ST_OFF3] = ~cw_new[drive_word_pkg::CW_ON3];
            st[drive_word_pkg::ST_LOCK_INH] = n.inhibit;
        end else begin
            // bits 4 and 5 left at zero
            st[drive_word_pkg::ST_CTRL_RDY] = COND_I.drive_ready;
            st[drive_word_pkg::ST_COAST] = cw_new[drive_word_pkg::CW_COAST] & ~r.trip;
            st[drive_word_pkg::ST_LOCK_INH] = r.lock;
        end
        n.status = st;

        // read port; unmapped addresses answer zero
        n.rdata = drive_word_pkg::RD_ZERO;
        if (RD_I) begin
            if (hit(ADDR_I, drive_word_pkg::OFS_CTRL)) begin
                n.rdata = z16(r.cw);
            end else if (hit(ADDR_I, drive_word_pkg::OFS_STATUS)) begin
                n.rdata = z16(r.status);
            end else if (hit(ADDR_I, drive_word_pkg::OFS_CFG)) begin
                n.rdata = {29'h0000_0000, r.cfg};
            end else if (hit(ADDR_I, drive_word_pkg::OFS_JOG1)) begin
                n.rdata = z16(r.jog1);
            end else if (hit(ADDR_I, drive_word_pkg::OFS_JOG2)) begin
                n.rdata = z16(r.jog2);
            end else if (hit(ADDR_I, drive_word_pkg::OFS_STEP)) begin
                n.rdata = z16(r.step);
            end else if (hit(ADDR_I, drive_word_pkg::OFS_REF)) begin
                n.rdata = z16(r.ref_val);
            end else if (hit(ADDR_I, drive_word_pkg::OFS_CURTIM)) begin
                n.rdata = z16(r.cur_time);
            end else if (hit(ADDR_I, drive_word_pkg::OFS_STATE)) begin
                n.rdata = {28'h000_0000, r.stop_pend, r.inhibit, r.lock, r.trip};
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            // reset stands for power-up, so start inhibit comes up set
            r <= '0;
            r.cfg <= drive_word_pkg::CFG_RST;
            r.cur_time <= drive_word_pkg::CURTIM_RST;
            r.inhibit <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign RDATA_O     = r.rdata;
    assign STATUS_O    = r.status;
    assign FREQ_CMD_O  = r.freq_cmd;
    assign RAMP_STOP_O = r.ramp_stop;
    assign RAMP2_SEL_O = r.ramp2;
    assign RELAY_O     = r.relay;
    assign START_OK_O  = r.start_ok;
    assign TRIP_O      = r.trip;

endmodule

`default_nettype wire

/* File: drive_word_ctrl_props.sv */
// port assertions for the drive control/status word block
// assumes one clock, synchronous active-high reset, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module drive_word_props (
    // clock and reset
    input  wire logic                          MCLK_I,
    input  wire logic                          RST_I,
    // register port
    input  wire logic [drive_word_pkg::AW-1:0] ADDR_I,
    input  wire logic [drive_word_pkg::DW-1:0] WDATA_I,
    input  wire logic                          WR_I,
    // drive side
    input  wire drive_word_pkg::drive_cond_s   COND_I,
    input  wire logic [drive_word_pkg::WW-1:0] STATUS_O,
    input  wire logic                          RAMP_STOP_O,
    input  wire logic                          RELAY_O,
    input  wire logic                          START_OK_O,
    input  wire logic                          TRIP_O
);
    logic up;
    logic wr7;
    // past-based checks are only meaningful one edge after reset
    always_ff @(posedge MCLK_I) up <= !RST_I;
    assign wr7 = WR_I && ADDR_I == drive_word_pkg::OFS_CTRL && WDATA_I[7];
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    warn_bit_a: assert property (up |-> STATUS_O[7] == $past(COND_I.warning))
        else $error("warning bit wrong");
    ref_bit_a: assert property (up |-> STATUS_O[8] == $past(COND_I.at_ref))
        else $error("at-reference bit wrong");
    serial_bit_a: assert property (up |-> STATUS_O[9] ==
        !$past(COND_I.panel_stop || COND_I.local_sel)) else $error("serial bit wrong");
    limit_bit_a: assert property (up |-> STATUS_O[10] == !$past(COND_I.at_freq_limit))
        else $error("limit bit wrong");
    run_bit_a: assert property (up |-> STATUS_O[11] ==
        $past(COND_I.start_sig || COND_I.freq_nonzero)) else $error("running bit wrong");
    volt_bit_a: assert property (up |-> STATUS_O[13] == $past(COND_I.dc_out_window))
        else $error("voltage bit wrong");
    cur_bit_a: assert property (up |-> STATUS_O[14] == $past(COND_I.over_current))
        else $error("current bit wrong");
    therm_bit_a: assert property (up |-> STATUS_O[15] == $past(COND_I.over_temp))
        else $error("thermal bit wrong");
    spare_bit_a: assert property (STATUS_O[12] == 1'b0)
        else $error("bit 12 not zero");
    trip_clear_a: assert property ($fell(TRIP_O) |-> !up || $past(wr7) || $past(wr7, 2))
        else $error("trip cleared without reset edge");
    relay_zero_a: assert property (up && RELAY_O |-> !$past(COND_I.freq_nonzero))
        else $error("relay on above 0 Hz");
    start_cond_a: assert property (up && START_OK_O |-> $past(COND_I.start_cond))
        else $error("start without start conditions");
    stop_start_a: assert property (!(RAMP_STOP_O && START_OK_O))
        else $error("ramp stop and start together");
    cover property ($fell(TRIP_O));
    cover property (RELAY_O);
    cover property (RAMP_STOP_O ##1 START_OK_O);
endmodule
bind drive_word_ctrl drive_word_props i_props (.MCLK_I(MCLK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .COND_I(COND_I),
    .STATUS_O(STATUS_O), .RAMP_STOP_O(RAMP_STOP_O), .RELAY_O(RELAY_O),
    .START_OK_O(START_OK_O), .TRIP_O(TRIP_O));
`default_nettype wire

/* File: bus_master_model.sv */
// serial master model: writes control words, reads status over the port
// assumes strobes sampled on the rising edge, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    // clock
    input  wire logic                          clk_i,
    // register port toward the block
    input  wire logic [drive_word_pkg::DW-1:0] rdata_i,
    output logic      [drive_word_pkg::AW-1:0] addr_o,
    output logic      [drive_word_pkg::DW-1:0] wdata_o,
    output logic                               wr_o,
    output logic                               rd_o
);
    initial begin
        addr_o  = 8'hFF;
        wdata_o = 32'hFFFFFFFF;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        // released lines flip so stale values never look valid
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the drive control/status word block
// assumes the master model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                        mclk = 1'b0;
    logic                        rst  = 1'b1;
    drive_word_pkg::drive_cond_s cond;
    drive_word_pkg::drive_cond_s base;
    drive_word_pkg::drive_cond_s c;
    logic [31:0] rdata, rd_v, wdata;
    logic [15:0] status, freq;
    logic [7:0]  addr;
    logic        wr, rd, ramp_stop, ramp2, relay, start_ok, trip;
    logic [15:0] mods [6] = '{16'h0800, 16'h1000, 16'h1800, 16'h0100, 16'h0200, 16'h0000};
    logic [15:0] exps [6] = '{16'h0FF0, 16'h1010, 16'h0FF0, 16'h0100, 16'h0200, 16'h1000};
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #10 mclk = ~mclk;
    bus_master_model i_bus (.clk_i(mclk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    drive_word_ctrl i_dut (.MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .COND_I(cond), .STATUS_O(status),
        .FREQ_CMD_O(freq), .RAMP_STOP_O(ramp_stop), .RAMP2_SEL_O(ramp2), .RELAY_O(relay),
        .START_OK_O(start_ok), .TRIP_O(trip));
    task automatic tally_and_finish();
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic cw(input logic [15:0] w);
        i_bus.wr(drive_word_pkg::OFS_CTRL, {16'h0000, w});
        settle();
    endtask
    task automatic setc(input drive_word_pkg::drive_cond_s v);
        @(posedge mclk);
        cond <= v;
        settle();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        i_bus.rd(a, rd_v);
        chk("rdata", e, rd_v & m);
    endtask
    // drive-ready bit is a designer choice, so it is masked out
    task automatic cs(input logic [15:0] e);
        chk("status", {16'h0000, e}, {16'h0000, status & 16'hFFFD});
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        base = '0;
        base.drive_ready = 1'b1;
        base.start_cond = 1'b1;
        cond = base;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rdc(drive_word_pkg::OFS_CFG, 32'hFFFFFFFF, 32'h00000000);
        rdc(drive_word_pkg::OFS_STATE, 32'h00000004, 32'h00000004);
        rdc(8'hFC, 32'hFFFFFFFF, 32'h00000000);
        cs(16'h0670);
        cw(16'h0406);
        cs(16'h0600);
        chk("ramp_stop", 32'h1, 32'(ramp_stop));
        cw(16'h040F);
        cs(16'h0605);
        chk("start_ok", 32'h1, 32'(start_ok));
        c = base;
        c.drive_ready = 1'b0;
        setc(c);
        cs(16'h0604);
        c = base;
        {c.warning, c.at_ref, c.start_sig, c.dc_out_window, c.over_temp} = 5'h1F;
        c.at_freq_limit = 1'b1;
        setc(c);
        cs(16'hAB85);
        setc(base);
        i_bus.wr(drive_word_pkg::OFS_JOG1, 32'h00000100);
        i_bus.wr(drive_word_pkg::OFS_JOG2, 32'h00000200);
        i_bus.wr(drive_word_pkg::OFS_STEP, 32'h00000010);
        i_bus.wr(drive_word_pkg::OFS_REF, 32'h00001000);
        for (int i = 0; i < 6; i++) begin
            cw(16'h040F | mods[i]);
            chk("freq", {16'h0000, exps[i]}, {16'h0000, freq});
        end
        cw(16'h0000);
        rdc(drive_word_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0000040F);
        for (int j = 0; j < 2; j++) begin
            c = base;
            if (j == 0) c.panel_stop = 1'b1;
            else c.local_sel = 1'b1;
            setc(c);
            cw(16'h0406);
            rdc(drive_word_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0000040F);
            chk("serial", 32'h0, 32'(status[9]));
        end
        i_bus.wr(drive_word_pkg::OFS_CFG, 32'h00000006);
        c = base;
        c.freq_nonzero = 1'b1;
        setc(c);
        cw(16'h040D);
        chk("ramp2", 32'h1, 32'(ramp_stop & ramp2 & ~start_ok));
        chk("off2", 32'h1, 32'(status[4] & status[11]));
        chk("relay", 32'h0, 32'(relay));
        setc(base);
        chk("relay", 32'h1, 32'(relay));
        rdc(drive_word_pkg::OFS_STATE, 32'h00000004, 32'h00000004);
        cw(16'h0406);
        cw(16'h040F);
        i_bus.wr(drive_word_pkg::OFS_CURTIM, 32'h00000004);
        c = base;
        c.over_current = 1'b1;
        for (int k = 0; k < 2; k++) begin
            setc(c);
            @(posedge mclk);
            #1;
            chk("trip", 32'h0, 32'(trip));
            repeat (2) @(posedge mclk);
            #1;
            chk("trip", 32'h1, 32'(trip & status[14] & ~status[2]));
            setc(base);
            cw(16'h048F);
            chk("trip", {31'h0, k[0]}, 32'(trip));
        end
        cw(16'h040F);
        cw(16'h048F);
        chk("trip", 32'h0, 32'(trip));
        rdc(drive_word_pkg::OFS_STATE, 32'h00000004, 32'h00000004);
        c = base;
        c.trip_evt = 1'b1;
        setc(c);
        setc(base);
        chk("trip", 32'h1, 32'(trip));
        cw(16'h040F);
        cw(16'h048F);
        chk("trip", 32'h0, 32'(trip));
        i_bus.wr(drive_word_pkg::OFS_CFG, 32'h00000001);
        cw(16'h0409);
        chk("unused", 32'h0, 32'(status[5:4]));
        c = base;
        c.lock_evt = 1'b1;
        setc(c);
        setc(base);
        chk("lock", 32'h1, 32'(status[6]));
        cw(16'h0489);
        rdc(drive_word_pkg::OFS_STATE, 32'h00000002, 32'h00000002);
        // supply cycle: only reset lifts the locked trip
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdc(drive_word_pkg::OFS_STATE, 32'h00000007, 32'h00000004);
        cs(16'h0670);
        tally_and_finish();
    end
endmodule
`default_nettype wire
